// ===== tpm_pkg.sv
// Purpose: timer constants
// Assumes: 8-bit port
// Notes: offsets are indices
`default_nettype none
package tpm_pkg;
    localparam logic [3:0] ADDR_CTRL2 = 4'h0;
    localparam logic [3:0] ADDR_CTRL1 = 4'h1;
    localparam logic [3:0] ADDR_FLAGS = 4'h2;
    localparam logic [3:0] ADDR_CAP1_HI = 4'h3;
    localparam logic [3:0] ADDR_CAP1_LO = 4'h4;
    localparam logic [3:0] ADDR_CMP1_HI = 4'h5;
    localparam logic [3:0] ADDR_CMP1_LO = 4'h6;
    localparam logic [3:0] ADDR_CNT_HI = 4'h7;
    localparam logic [3:0] ADDR_CNT_LO = 4'h8;
    localparam logic [3:0] ADDR_CAP2_HI = 4'h9;
    localparam logic [3:0] ADDR_CAP2_LO = 4'hA;
    localparam logic [3:0] ADDR_CMP2_HI = 4'hB;
    localparam logic [3:0] ADDR_CMP2_LO = 4'hC;
    // first control register fields
    localparam int C1_CAP_IRQ_EN = 7;
    localparam int C1_CMP_IRQ_EN = 6;
    localparam int C1_FORCE2 = 4;
    localparam int C1_FORCE1 = 3;
    localparam int C1_PULSE_LVL = 2;
    localparam int C1_EDGE1 = 1;
    localparam int C1_AFTER_LVL = 0;
    // second control register fields
    localparam int C2_PIN1_EN = 7;
    localparam int C2_PIN2_EN = 6;
    localparam int C2_SINGLE_SHOT = 5;
    localparam int C2_PWM = 4;
    localparam int C2_CLK_SEL_HI = 3;
    localparam int C2_CLK_SEL_LO = 2;
    localparam int C2_EDGE2 = 1;
    localparam int C2_EXT_EDGE = 0;
    // flags register fields
    localparam int FL_CAP1 = 7;
    localparam int FL_CMP1 = 6;
    localparam int FL_CAP2 = 4;
    localparam int FL_CMP2 = 3;
    // reset and load values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [15:0] CNT_RESET = 16'hFFFC;
    localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
    localparam logic [15:0] CAP_TRIGGER_VALUE = 16'hFFFD;
    // timer clock selections and division counts
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    localparam logic [2:0] DIV2_LAST = 3'h1;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    typedef enum logic [1:0] {TPM_NORMAL, TPM_SINGLE_SHOT, TPM_PWM} tpm_mode_e;
endpackage
`default_nettype wire

// ===== tpm_edge.sv
// Purpose: pin edge detector
// Assumes: synchronous pin
// Notes: one-cycle pulse
`default_nettype none
module tpm_edge (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic rising_sel,
    output logic edge_pulse
);
    logic pin_prev;
    wire rise = pin & ~pin_prev;
    wire fall = ~pin & pin_prev;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= pin;
        end
    end

    assign edge_pulse = rising_sel ? rise : fall;
endmodule
`default_nettype wire

// ===== tpm_tick.sv
// Purpose: timer tick enable
// Assumes: ext clock below core_clk/4
// Notes: run low freezes prescaler
`default_nettype none
module tpm_tick (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] clk_sel,
    input wire logic ext_pin,
    input wire logic ext_rising,
    output logic tick
);
    logic [2:0] div_cnt;
    logic ext_edge;
    wire [2:0] div_last = (clk_sel == tpm_pkg::CLK_DIV2) ? tpm_pkg::DIV2_LAST :
                          (clk_sel == tpm_pkg::CLK_DIV8) ? tpm_pkg::DIV8_LAST :
                          tpm_pkg::DIV4_LAST;
    wire use_ext = (clk_sel == tpm_pkg::CLK_EXT);
    wire div_wrap = (div_cnt >= div_last);

    tpm_edge u_ext_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(ext_pin),
        .rising_sel(ext_rising),
        .edge_pulse(ext_edge)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_cnt <= 3'h0;
        end else if (run && !use_ext) begin
            div_cnt <= div_wrap ? 3'h0 : div_cnt + 3'h1;
        end
    end

    // one count per period or edge
    assign tick = run & (use_ext ? ext_edge : div_wrap);
endmodule
`default_nettype wire

// ===== tpm_timer.sv
// Purpose: 16-bit timer, forced/shot/pwm outputs
// Assumes: read data one cycle after strobe
// Notes: halt_mode stops counting
//
// What this block does
// - force copies level bit, no flag
// - force ignored in special modes
// - shot mode uses channel one
// - trigger: reload, pulse level, flag, FFFDh
// - shot: compare one match ends pulse
// - shot: only compare flag two sets
// - shot: no waveform on second pin
// - both mode bits mean pwm
// - no capture one in special modes
// - trigger flag may interrupt
// - flag clear: status read, low access
// - pwm compare writes wait period end
// - pwm: match one after level, two pulse
// - pwm match two reloads FFFCh
// - width is first minus FFFCh, plus one tick
// - high write inhibits until low write
// - pwm: no compare flags, period flag
// - wait: timer runs, interrupt wakes
// - halt freezes count, resumes held value
// - halt edge armed, captured at exit
//
// Local design decisions: the address map and the address-and-strobe port.
`default_nettype none
module tpm_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic first_capture_pin,
    input wire logic second_capture_pin,
    input wire logic ext_clk_pin,
    input wire logic halt_mode,
    input wire logic wait_mode,
    output logic first_compare_pin,
    output logic first_compare_pin_oe,
    output logic second_compare_pin,
    output logic second_compare_pin_oe,
    output logic timer_irq
);
    logic [7:0] first_control_register;
    logic [7:0] second_control_register;
    logic [15:0] first_compare_value;
    logic [15:0] second_compare_value;
    logic [15:0] first_compare_active;
    logic [15:0] second_compare_active;
    logic [15:0] first_capture_value;
    logic [15:0] second_capture_value;
    logic [15:0] count;
    logic first_capture_flag;
    logic second_capture_flag;
    logic first_compare_flag;
    logic second_compare_flag;
    logic [3:0] clear_armed;
    logic cmp1_inhibit;
    logic cmp2_inhibit;
    logic halt_prev;
    logic [1:0] halt_cap_armed;
    logic tick;
    logic edge1;
    logic edge2;

    function automatic logic acc(input logic [3:0] a, input logic [3:0] target,
                                 input logic rd, input logic wr);
        acc = (rd | wr) & (a == target);
    endfunction

    // control decode
    wire capture_irq_enable = first_control_register[tpm_pkg::C1_CAP_IRQ_EN];
    wire compare_pin_enable = first_control_register[tpm_pkg::C1_CMP_IRQ_EN];
    wire force1 = first_control_register[tpm_pkg::C1_FORCE1];
    wire force2 = first_control_register[tpm_pkg::C1_FORCE2];
    wire after_level_bit = first_control_register[tpm_pkg::C1_AFTER_LVL];
    wire pulse_level_bit = first_control_register[tpm_pkg::C1_PULSE_LVL];
    wire first_capture_edge_select = first_control_register[tpm_pkg::C1_EDGE1];
    wire first_compare_pin_enable = second_control_register[tpm_pkg::C2_PIN1_EN];
    wire second_compare_pin_enable = second_control_register[tpm_pkg::C2_PIN2_EN];
    wire single_shot_mode_bit = second_control_register[tpm_pkg::C2_SINGLE_SHOT];
    wire pwm_mode_bit = second_control_register[tpm_pkg::C2_PWM];
    wire [1:0] timer_clock_select =
        second_control_register[tpm_pkg::C2_CLK_SEL_HI:tpm_pkg::C2_CLK_SEL_LO];

    tpm_pkg::tpm_mode_e mode;
    assign mode = pwm_mode_bit ? tpm_pkg::TPM_PWM :
                  single_shot_mode_bit ? tpm_pkg::TPM_SINGLE_SHOT : tpm_pkg::TPM_NORMAL;
    wire is_pwm = (mode == tpm_pkg::TPM_PWM);
    wire is_shot = (mode == tpm_pkg::TPM_SINGLE_SHOT);
    wire is_normal = (mode == tpm_pkg::TPM_NORMAL);

    // bus decode
    wire wr_ctrl1 = reg_wr & (reg_addr == tpm_pkg::ADDR_CTRL1);
    wire wr_ctrl2 = reg_wr & (reg_addr == tpm_pkg::ADDR_CTRL2);
    wire wr_c1_hi = reg_wr & (reg_addr == tpm_pkg::ADDR_CMP1_HI);
    wire wr_c1_lo = reg_wr & (reg_addr == tpm_pkg::ADDR_CMP1_LO);
    wire wr_c2_hi = reg_wr & (reg_addr == tpm_pkg::ADDR_CMP2_HI);
    wire wr_c2_lo = reg_wr & (reg_addr == tpm_pkg::ADDR_CMP2_LO);
    wire rd_flags = reg_rd & (reg_addr == tpm_pkg::ADDR_FLAGS);
    wire acc_cap1_lo = acc(reg_addr, tpm_pkg::ADDR_CAP1_LO, reg_rd, reg_wr);
    wire acc_cap2_lo = acc(reg_addr, tpm_pkg::ADDR_CAP2_LO, reg_rd, reg_wr);
    wire acc_cmp1_lo = acc(reg_addr, tpm_pkg::ADDR_CMP1_LO, reg_rd, reg_wr);
    wire acc_cmp2_lo = acc(reg_addr, tpm_pkg::ADDR_CMP2_LO, reg_rd, reg_wr);

    // timer clock and pin edges
    tpm_tick u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(~halt_mode),
        .clk_sel(timer_clock_select),
        .ext_pin(ext_clk_pin),
        .ext_rising(second_control_register[tpm_pkg::C2_EXT_EDGE]),
        .tick(tick)
    );

    tpm_edge u_cap1_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(first_capture_pin),
        .rising_sel(first_capture_edge_select),
        .edge_pulse(edge1)
    );

    tpm_edge u_cap2_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(second_capture_pin),
        .rising_sel(second_control_register[tpm_pkg::C2_EDGE2]),
        .edge_pulse(edge2)
    );

    // pwm uses shadows
    wire [15:0] cmp1_eff = is_pwm ? first_compare_active : first_compare_value;
    wire [15:0] cmp2_eff = is_pwm ? second_compare_active : second_compare_value;
    wire match1 = tick & ~cmp1_inhibit & (count == cmp1_eff);
    wire match2 = tick & ~cmp2_inhibit & (count == cmp2_eff);
    wire shot_trigger = is_shot & edge1 & ~halt_mode;
    wire pwm_period_end = is_pwm & match2;
    wire halt_exit = halt_prev & ~halt_mode;

    // capture events: first pin only in normal mode
    wire cap1_live = is_normal & edge1 & ~halt_mode;
    wire cap1_wake = halt_exit & halt_cap_armed[0];
    wire cap2_live = edge2 & ~halt_mode;
    wire cap2_wake = halt_exit & halt_cap_armed[1];
    wire set_first_capture_flag = cap1_live | cap1_wake | shot_trigger | pwm_period_end;
    wire set_second_capture_flag = cap2_live | cap2_wake;

    // compare flag one in normal only, two in normal or shot; not while forced in normal mode
    wire set_first_compare_flag = is_normal & match1 & ~force1;
    wire set_second_compare_flag = (is_normal & ~force2 | is_shot) & match2;

    wire [3:0] flag_now = {second_compare_flag, first_compare_flag,
                           second_capture_flag, first_capture_flag};
    wire [3:0] clear_acc = {acc_cmp2_lo, acc_cmp1_lo, acc_cap2_lo, acc_cap1_lo};
    wire [3:0] flag_set = {set_second_compare_flag, set_first_compare_flag, set_second_capture_flag, set_first_capture_flag};
    wire [3:0] flag_clear = clear_armed & clear_acc;
    wire [3:0] next_flags = flag_set | (flag_now & ~flag_clear);

    wire [7:0] flags_view = {first_capture_flag, first_compare_flag, 1'b0,
                             second_capture_flag, second_compare_flag, 3'h0};

    logic [7:0] next_rdata;
    always_comb begin
        unique case (reg_addr)
            tpm_pkg::ADDR_CTRL2: next_rdata = second_control_register;
            tpm_pkg::ADDR_CTRL1: next_rdata = first_control_register;
            tpm_pkg::ADDR_FLAGS: next_rdata = flags_view;
            tpm_pkg::ADDR_CAP1_HI: next_rdata = first_capture_value[15:8];
            tpm_pkg::ADDR_CAP1_LO: next_rdata = first_capture_value[7:0];
            tpm_pkg::ADDR_CMP1_HI: next_rdata = first_compare_value[15:8];
            tpm_pkg::ADDR_CMP1_LO: next_rdata = first_compare_value[7:0];
            tpm_pkg::ADDR_CNT_HI: next_rdata = count[15:8];
            tpm_pkg::ADDR_CNT_LO: next_rdata = count[7:0];
            tpm_pkg::ADDR_CAP2_HI: next_rdata = second_capture_value[15:8];
            tpm_pkg::ADDR_CAP2_LO: next_rdata = second_capture_value[7:0];
            tpm_pkg::ADDR_CMP2_HI: next_rdata = second_compare_value[15:8];
            tpm_pkg::ADDR_CMP2_LO: next_rdata = second_compare_value[7:0];
            default: next_rdata = 8'h00;
        endcase
    end

    // counter
    wire [15:0] next_count = (shot_trigger | pwm_period_end) ? tpm_pkg::CNT_RELOAD :
                             tick ? count + 16'h0001 : count;

    // first compare pin level
    logic next_pin1;
    always_comb begin
        next_pin1 = first_compare_pin;
        unique case (mode)
            tpm_pkg::TPM_PWM: begin
                if (match2) begin
                    next_pin1 = pulse_level_bit;
                end else if (match1) begin
                    next_pin1 = after_level_bit;
                end
            end
            tpm_pkg::TPM_SINGLE_SHOT: begin
                if (shot_trigger) begin
                    next_pin1 = pulse_level_bit;
                end else if (match1) begin
                    next_pin1 = after_level_bit;
                end
            end
            tpm_pkg::TPM_NORMAL: begin
                if (force1 || match1) begin
                    next_pin1 = after_level_bit;
                end
            end
        endcase
    end

    // second pin: normal mode only
    wire next_pin2 = (is_normal & (force2 | match2)) ? pulse_level_bit :
                     second_compare_pin;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            first_control_register <= tpm_pkg::CTRL_RESET;
            second_control_register <= tpm_pkg::CTRL_RESET;
        end else begin
            if (wr_ctrl1) begin
                first_control_register <= reg_wdata;
            end
            if (wr_ctrl2) begin
                second_control_register <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            first_compare_value <= tpm_pkg::CMP_RESET;
            second_compare_value <= tpm_pkg::CMP_RESET;
            cmp1_inhibit <= 1'b0;
            cmp2_inhibit <= 1'b0;
        end else begin
            if (wr_c1_hi) begin
                first_compare_value[15:8] <= reg_wdata;
            end
            if (wr_c1_lo) begin
                first_compare_value[7:0] <= reg_wdata;
            end
            if (wr_c2_hi) begin
                second_compare_value[15:8] <= reg_wdata;
            end
            if (wr_c2_lo) begin
                second_compare_value[7:0] <= reg_wdata;
            end
            cmp1_inhibit <= wr_c1_hi | (cmp1_inhibit & ~wr_c1_lo);
            cmp2_inhibit <= wr_c2_hi | (cmp2_inhibit & ~wr_c2_lo);
        end
    end

    // shadows track values outside pwm
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            first_compare_active <= tpm_pkg::CMP_RESET;
            second_compare_active <= tpm_pkg::CMP_RESET;
        end else if (!is_pwm || pwm_period_end) begin
            first_compare_active <= first_compare_value;
            second_compare_active <= second_compare_value;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count <= tpm_pkg::CNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            first_capture_value <= 16'h0000;
            second_capture_value <= 16'h0000;
        end else begin
            if (shot_trigger) begin
                first_capture_value <= tpm_pkg::CAP_TRIGGER_VALUE;
            end else if (cap1_live || cap1_wake) begin
                first_capture_value <= count;
            end
            if (cap2_live || cap2_wake) begin
                second_capture_value <= count;
            end
        end
    end

    // two-step clear arming
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            clear_armed <= 4'h0;
        end else begin
            clear_armed <= ((rd_flags ? flag_now : 4'h0) | clear_armed) & ~clear_acc;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            {second_compare_flag, first_compare_flag,
             second_capture_flag, first_capture_flag} <= 4'h0;
        end else begin
            {second_compare_flag, first_compare_flag,
             second_capture_flag, first_capture_flag} <= next_flags;
        end
    end

    // halt edges wait for exit
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            halt_prev <= 1'b0;
            halt_cap_armed <= 2'h0;
        end else begin
            halt_prev <= halt_mode;
            if (halt_exit) begin
                halt_cap_armed <= 2'h0;
            end else if (halt_mode) begin
                halt_cap_armed <= halt_cap_armed | {edge2, edge1 & is_normal};
            end
        end
    end

    // outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            first_compare_pin <= 1'b0;
            second_compare_pin <= 1'b0;
            first_compare_pin_oe <= 1'b0;
            second_compare_pin_oe <= 1'b0;
            reg_rdata <= 8'h00;
            timer_irq <= 1'b0;
        end else begin
            first_compare_pin <= next_pin1;
            second_compare_pin <= next_pin2;
            first_compare_pin_oe <= first_compare_pin_enable;
            second_compare_pin_oe <= second_compare_pin_enable & is_normal;
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
            // wait wake source
            timer_irq <= (capture_irq_enable & (next_flags[0] | next_flags[1])) |
                         (compare_pin_enable & (next_flags[2] | next_flags[3]));
        end
    end

    wire unused_wait = wait_mode;
endmodule
`default_nettype wire

// ===== tpm_timer_chk.sv
// Purpose: timer port checks
// Assumes: control snooped from writes
// Notes: quiet counts since control write
`default_nettype none
module tpm_timer_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic first_capture_pin,
    input wire logic halt_mode,
    input wire logic first_compare_pin,
    input wire logic first_compare_pin_oe,
    input wire logic second_compare_pin,
    input wire logic second_compare_pin_oe,
    input wire logic timer_irq
);
    logic [7:0] c1;
    logic [7:0] c2;
    logic [1:0] quiet;
    logic [1:0] hcnt;
    wire wr1 = reg_wr && (reg_addr == tpm_pkg::ADDR_CTRL1);
    wire wr2 = reg_wr && (reg_addr == tpm_pkg::ADDR_CTRL2);
    wire special = c2[tpm_pkg::C2_SINGLE_SHOT] | c2[tpm_pkg::C2_PWM];
    wire shot = c2[tpm_pkg::C2_SINGLE_SHOT] & ~c2[tpm_pkg::C2_PWM];
    wire settled = (quiet == 2'h3) && !wr1 && !wr2;
    always_ff @(posedge core_clk) begin
        c1 <= !rst_n ? 8'h00 : (wr1 ? reg_wdata : c1);
        c2 <= !rst_n ? 8'h00 : (wr2 ? reg_wdata : c2);
    end
    always_ff @(posedge core_clk) begin
        quiet <= (!rst_n || wr1 || wr2) ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
        hcnt <= (!rst_n || !halt_mode) ? 2'h0 : (hcnt == 2'h3 ? hcnt : hcnt + 2'h1);
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_force_level: assert property (settled && !special && c1[tpm_pkg::C1_FORCE1] &&
        c2[tpm_pkg::C2_PIN1_EN] |-> first_compare_pin == c1[tpm_pkg::C1_AFTER_LVL])
        else $error("forced pin level");
    a_pin_enable: assert property (settled |-> first_compare_pin_oe == c2[tpm_pkg::C2_PIN1_EN])
        else $error("pin enable wrong");
    a_second_quiet: assert property (settled && special |->
        !second_compare_pin_oe && $stable(second_compare_pin))
        else $error("second pin active");
    a_trigger_pulse: assert property (settled && shot && $rose(first_capture_pin)
        && c1[tpm_pkg::C1_EDGE1] |-> ##[1:3] first_compare_pin == c1[tpm_pkg::C1_PULSE_LVL])
        else $error("no pulse start");
    a_trigger_irq: assert property (settled && shot && $rose(first_capture_pin)
        && c1[tpm_pkg::C1_EDGE1] && c1[tpm_pkg::C1_CAP_IRQ_EN] |-> ##[1:4] timer_irq)
        else $error("no trigger irq");
    a_irq_gated: assert property (settled && !c1[7] && !c1[6] |-> !timer_irq)
        else $error("interrupt without enable");
    a_equal_levels: assert property (settled && special &&
        c1[tpm_pkg::C1_AFTER_LVL] == c1[tpm_pkg::C1_PULSE_LVL] &&
        first_compare_pin == c1[tpm_pkg::C1_AFTER_LVL] |=> $stable(first_compare_pin))
        else $error("equal levels moved");
    a_pwm_no_cmp: assert property (settled && c2[tpm_pkg::C2_PWM] &&
        !c1[tpm_pkg::C1_CAP_IRQ_EN] && !timer_irq |=> !timer_irq)
        else $error("pwm compare irq");
    a_halt_hold: assert property (settled && hcnt == 2'h3 |-> $stable(first_compare_pin))
        else $error("output moved during halt");
    c_shot: cover property (shot && $rose(first_compare_pin));
    c_pwm: cover property (c2[tpm_pkg::C2_PWM] && $fell(first_compare_pin));
    c_halt: cover property (hcnt == 2'h3);
endmodule
`default_nettype wire

// ===== tpm_board.sv
// Purpose: trigger and ext clock pins
// Assumes: one-cycle requests
// Notes: four-cycle pulses, twenty ext edges
`default_nettype none
module tpm_board (
    input wire logic core_clk,
    input wire logic trig1,
    input wire logic trig2,
    input wire logic ext_go,
    output logic first_capture_pin,
    output logic second_capture_pin,
    output logic ext_clk_pin,
    output logic ext_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hold1 = 3'h0;
    logic [2:0] hold2 = 3'h0;
    logic [4:0] toggles = 5'h00;
    logic [1:0] gap = 2'h0;
    logic ext_lvl = 1'b0;
    assign first_capture_pin = hold1 != 3'h0;
    assign second_capture_pin = hold2 != 3'h0;
    assign ext_clk_pin = ext_lvl;
    assign ext_busy = toggles != 5'h00;
    always @(posedge core_clk) begin
        hold1 <= trig1 ? 3'h4 : (hold1 != 3'h0 ? hold1 - 3'h1 : hold1);
        hold2 <= trig2 ? 3'h4 : (hold2 != 3'h0 ? hold2 - 3'h1 : hold2);
        gap <= gap + 2'h1;
        // edges four cycles apart
        if (ext_go) begin
            toggles <= 5'd20;
        end else if (gap == 2'h3 && toggles != 5'h00) begin
            ext_lvl <= !ext_lvl;
            toggles <= toggles - 5'h01;
        end
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: register-level timer test
// Assumes: read data one cycle late
// Notes: widths in core cycles, div 2
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, reg_wr, reg_rd, halt_mode, wait_mode, trig1, trig2, ext_go;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v, c0;
    logic first_capture_pin, second_capture_pin, ext_clk_pin, ext_busy, timer_irq;
    logic first_compare_pin, first_compare_pin_oe, second_compare_pin, second_compare_pin_oe;
    int num_errors, checked, w;
    tpm_timer u_tpm_timer (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_capture_pin(first_capture_pin), .second_capture_pin(second_capture_pin),
        .ext_clk_pin(ext_clk_pin), .halt_mode(halt_mode), .wait_mode(wait_mode),
        .first_compare_pin(first_compare_pin), .first_compare_pin_oe(first_compare_pin_oe),
        .second_compare_pin(second_compare_pin), .second_compare_pin_oe(second_compare_pin_oe),
        .timer_irq(timer_irq));
    tpm_board u_tpm_board (.core_clk(core_clk), .trig1(trig1), .trig2(trig2), .ext_go(ext_go),
        .first_capture_pin(first_capture_pin), .second_capture_pin(second_capture_pin),
        .ext_clk_pin(ext_clk_pin), .ext_busy(ext_busy));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = !core_clk;
    end
    task end_sim;
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rdv(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] exp);
        rdv(a);
        chk({8'h00, v}, {8'h00, exp});
    endtask
    task pin_wait(input logic lvl);
        w = 0;
        while (first_compare_pin !== lvl) begin
            @(posedge core_clk);
            #1;
            w++;
            if (w > 3000) begin
                num_errors++;
                end_sim();
            end
        end
    endtask
    task pulse(input logic a, input logic b);
        @(posedge core_clk);
        trig1 <= a;
        trig2 <= b;
        @(posedge core_clk);
        trig1 <= 1'b0;
        trig2 <= 1'b0;
    endtask
    initial begin
        {reg_wr, reg_rd, halt_mode, wait_mode, trig1, trig2, ext_go} = '0;
        {reg_addr, reg_wdata, num_errors, checked, w} = '0;
        rst_n = 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(tpm_pkg::ADDR_CTRL1, tpm_pkg::CTRL_RESET);
        rd(tpm_pkg::ADDR_CMP1_HI, tpm_pkg::CMP_RESET[15:8]);
        rd(tpm_pkg::ADDR_CNT_HI, tpm_pkg::CNT_RESET[15:8]);
        rd(4'hD, 8'h00);
        wr(tpm_pkg::ADDR_CTRL2, 8'hC0);
        wr(tpm_pkg::ADDR_CTRL1, 8'h1D);
        repeat (3) @(posedge core_clk);
        chk(16'({first_compare_pin, second_compare_pin}), 16'h0003);
        wr(tpm_pkg::ADDR_CTRL1, 8'h18);
        repeat (3) @(posedge core_clk);
        chk(16'({first_compare_pin, second_compare_pin}), 16'h0000);
        rd(tpm_pkg::ADDR_FLAGS, 8'h00);
        wr(tpm_pkg::ADDR_CMP1_HI, 8'h00);
        wr(tpm_pkg::ADDR_CMP1_LO, 8'h0A);
        wr(tpm_pkg::ADDR_CTRL1, 8'h9E);
        wr(tpm_pkg::ADDR_CTRL2, 8'hA4);
        pulse(1'b1, 1'b0);
        pin_wait(1'b1);
        chk(16'(timer_irq), 16'h0001);
        pin_wait(1'b0);
        chk(16'(w >= 28 && w <= 31), 16'h0001);
        rd(tpm_pkg::ADDR_FLAGS, 8'h80);
        rd(tpm_pkg::ADDR_CAP1_HI, 8'hFF);
        rd(tpm_pkg::ADDR_CAP1_LO, 8'hFD);
        rd(tpm_pkg::ADDR_FLAGS, 8'h00);
        pulse(1'b1, 1'b1);
        repeat (40) @(posedge core_clk);
        rd(tpm_pkg::ADDR_CAP1_LO, 8'hFD);
        rd(tpm_pkg::ADDR_FLAGS, 8'h90);
        rd(tpm_pkg::ADDR_CAP1_LO, 8'hFD);
        rdv(tpm_pkg::ADDR_CAP2_LO);
        rd(tpm_pkg::ADDR_FLAGS, 8'h00);
        chk(16'(timer_irq), 16'h0000);
        wr(tpm_pkg::ADDR_CMP2_HI, 8'h00);
        wr(tpm_pkg::ADDR_CMP2_LO, 8'h0A);
        wr(tpm_pkg::ADDR_CMP1_LO, 8'h04);
        wr(tpm_pkg::ADDR_CTRL1, 8'h4B);
        pulse(1'b1, 1'b0);
        wr(tpm_pkg::ADDR_CTRL2, 8'hB4);
        pin_wait(1'b1);
        pin_wait(1'b0);
        wr(tpm_pkg::ADDR_CMP1_LO, 8'h06);
        pin_wait(1'b1);
        chk(16'(w), 16'd16);
        pin_wait(1'b0);
        chk(16'(w), 16'd12);
        pin_wait(1'b1);
        pin_wait(1'b0);
        chk(16'(w), 16'd8);
        rd(tpm_pkg::ADDR_FLAGS, 8'h80);
        chk(16'(timer_irq), 16'h0000);
        wr(tpm_pkg::ADDR_CTRL1, 8'h00);
        wr(tpm_pkg::ADDR_CTRL2, 8'h00);
        rdv(tpm_pkg::ADDR_FLAGS);
        rdv(tpm_pkg::ADDR_CAP1_LO);
        halt_mode <= 1'b1;
        rdv(tpm_pkg::ADDR_CNT_LO);
        c0 = v;
        pulse(1'b0, 1'b1);
        repeat (20) @(posedge core_clk);
        rd(tpm_pkg::ADDR_CNT_LO, c0);
        rd(tpm_pkg::ADDR_FLAGS, 8'h00);
        halt_mode <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(tpm_pkg::ADDR_FLAGS, 8'h10);
        rd(tpm_pkg::ADDR_CAP2_LO, c0);
        wr(tpm_pkg::ADDR_CTRL2, 8'h0D);
        wait_mode <= 1'b1;
        rdv(tpm_pkg::ADDR_CNT_LO);
        c0 = v;
        ext_go <= 1'b1;
        @(posedge core_clk);
        ext_go <= 1'b0;
        repeat (200) @(posedge core_clk);
        chk(16'(ext_busy), 16'h0000);
        rd(tpm_pkg::ADDR_CNT_LO, 8'(c0 + 8'h0A));
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        end_sim();
    end
endmodule
bind tpm_timer tpm_timer_chk u_tpm_timer_chk (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .first_capture_pin(first_capture_pin), .halt_mode(halt_mode),
    .first_compare_pin(first_compare_pin), .first_compare_pin_oe(first_compare_pin_oe),
    .second_compare_pin(second_compare_pin), .second_compare_pin_oe(second_compare_pin_oe),
    .timer_irq(timer_irq));
`default_nettype wire
